// [lpw_sequencer.sv]
// Low-power mode controller and wake sequencer with APB registers
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lpw_regs.svh"
// Contract
// RULE1: Sleep stops the core clock; peripherals keep running and interrupt.
// RULE2: Sleep suspends execution until reset or interrupt.
// RULE3: Sleep exit only re-enables the core clock.
// RULE4: Deep-sleep stops main oscillator and all internal clocks; state kept.
// RULE5: Deep-sleep gates the internal RC output but keeps it powered.
// RULE6: RTC oscillator keeps running in deep-sleep.
// RULE7: Deep-sleep entry turns PLL off and clears CPU and USB dividers.
// RULE8: Deep-sleep ends only on reset or a clockless wake interrupt.
// RULE9: Flash power stays on throughout deep-sleep.
// RULE10: Deep-sleep wake from internal RC resumes after 4 oscillator cycles.
// RULE11: Deep-sleep wake from main oscillator resumes after 4096 cycles.
// RULE12: Software reconfigures PLL and dividers after deep-sleep or power-down.
// RULE13: Power-down also removes power from internal RC and flash.
// RULE14: Power-down wake: 60 us RC start-up, then 4 cycles; with main oscillator the code waits OSC_WAKE_CYC.
// RULE15: Flash timer covers 100 us start-up before flash access.
// RULE16: Every power-down wake passes through the wake-up timer.
// RULE17: Deep power-down is entered only on request from the RTC.
// RULE18: Deep power-down removes power except RTC and reset pin.
// RULE19: Deep power-down wakes only on reset pin or RTC alarm.
// RULE20: Interrupt controller hands over wake mask on deep mode entry.
// RULE21: Wake logic watches masked interrupts and wakes without polling.
// RULE22: Each peripheral clock is gated by its own control bit.
// RULE23: Software selects mode; wait-for-interrupt enters it, mode held stable.
module lpw_sequencer #(
    parameter int N_IRQ = 32,
    parameter int N_PERIPH = 32,
    parameter logic [15:0] OSC_WAKE_CYC = 16'(`LPW_OSC_WAKE_OSC)
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // APB slave
    input wire lpw_pkg::lpw_apb_req_t apb_req,
    output lpw_pkg::lpw_apb_rsp_t apb_rsp,
    // Processor core and nested_interrupt_ctrl
    input wire logic core_wfi,
    input wire logic [N_IRQ-1:0] nic_wake_mask,
    // Asynchronous wake sources and RTC domain
    input wire logic [N_IRQ-1:0] irq_in,
    input wire logic rtc_dpd_req,
    input wire logic rtc_alarm,
    // Power, clock and reconfiguration controls
    output lpw_pkg::lpw_pwr_t pwr_ctl,
    output logic pll_en,
    output logic [7:0] cpu_div,
    output logic [7:0] usb_div,
    output logic [N_PERIPH-1:0] periph_clk_en,
    output logic [2:0] seq_state
);
    import lpw_pkg::*;

    // --------------------------------------------------------
    // Synchronisers for pins and the RTC domain
    // --------------------------------------------------------
    logic [N_IRQ+1:0] sync1_reg;
    logic [N_IRQ+1:0] sync2_reg;

    wire [N_IRQ-1:0] irq_s = sync2_reg[N_IRQ-1:0];
    wire dpd_req_s = sync2_reg[N_IRQ];
    wire alarm_s = sync2_reg[N_IRQ+1];

    // Two flops per line; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (clk_en) begin
            sync1_reg <= {rtc_alarm, rtc_dpd_req, irq_in};
            sync2_reg <= sync1_reg;
        end
    end

    // --------------------------------------------------------
    // Registers and sequencer state
    // --------------------------------------------------------
    logic [2:0] mode_reg;
    logic [N_PERIPH-1:0] pgate_reg;
    logic [16:0] clkcfg_reg;
    logic [16:0] clkcfg_next;

    lpw_state_t state_reg;
    lpw_state_t state_next;

    logic [N_IRQ-1:0] mask_reg;
    logic [15:0] wcnt_reg;
    logic [15:0] wcnt_next;
    logic [15:0] fcnt_reg;
    logic [15:0] fcnt_next;

    logic from_pd_reg;
    lpw_pwr_t pwr_next;

    lpw_apb_rsp_t rsp_reg;

    // --------------------------------------------------------
    // APB decode
    // --------------------------------------------------------
    // Answer one cycle into the access phase; pready is a flop
    wire acc = apb_req.psel && apb_req.penable && !rsp_reg.pready;
    wire hit_mode = apb_req.paddr == `LPW_OFS_MODE;
    wire hit_pgate = apb_req.paddr == `LPW_OFS_PGATE;
    wire hit_cfg = apb_req.paddr == `LPW_OFS_CLKCFG;
    wire hit_stat = apb_req.paddr == `LPW_OFS_STATUS;
    wire hit_any = hit_mode || hit_pgate || hit_cfg || hit_stat;


    wire wr = acc && apb_req.pwrite;
    wire [31:0] wd = apb_req.pwdata;

    wire [31:0] rd_mode = {29'h0, mode_reg};
    wire [31:0] rd_pgate = 32'(pgate_reg);
    wire [31:0] rd_cfg = {15'h0, clkcfg_reg};
    wire [31:0] rd_stat = {28'h0, pwr_ctl.flash_ready, state_reg};
    wire [31:0] rd_data = hit_mode ? rd_mode :
                          hit_pgate ? rd_pgate :
                          hit_cfg ? rd_cfg :
                          hit_stat ? rd_stat : 32'h0;

    // --------------------------------------------------------
    // Wake detection and mode selection
    // --------------------------------------------------------
    // Purely combinational watch: no periodic polling is needed
    wire irq_masked = |(irq_s & mask_reg); // see RULE21
    wire irq_any = |irq_s;

    wire src_main = mode_reg[`LPW_SRC_BIT];
    wire [1:0] sel_mode = mode_reg[`LPW_MODE_MSB:`LPW_MODE_LSB];

    wire deep_entry = (state_reg == LPW_S_RUN) && core_wfi &&
                      (sel_mode == LPW_M_DSLEEP || sel_mode == LPW_M_PDOWN);
    // Mode code 3 is refused so deep power-down has no software path
    wire wfi_ok = core_wfi && sel_mode != LPW_M_RSVD; // see RULE17

    wire [15:0] resume_cyc = src_main ? OSC_WAKE_CYC :
                             16'(`LPW_IRC_WAKE_CYC);

    // --------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        wcnt_next = wcnt_reg;
        case (state_reg)
            LPW_S_RUN: begin
                if (dpd_req_s) begin
                    state_next = LPW_S_DPD; // see RULE17
                end else if (wfi_ok) begin
                    // Entered on wait-for-interrupt, mode as written
                    case (sel_mode) // see RULE23
                        LPW_M_SLEEP: state_next = LPW_S_SLEEP;
                        LPW_M_DSLEEP: state_next = LPW_S_DSLEEP;
                        default: state_next = LPW_S_PDOWN;
                    endcase
                end
            end
            LPW_S_SLEEP: begin
                // Any peripheral interrupt restarts the core clock
                if (irq_any) begin
                    state_next = LPW_S_RUN; // see RULE2, RULE3
                end
            end
            LPW_S_DSLEEP: begin
                if (irq_masked) begin
                    state_next = LPW_S_WCNT; // see RULE8
                    wcnt_next = resume_cyc; // see RULE10, RULE11
                end
            end
            LPW_S_PDOWN: begin
                if (irq_masked) begin
                    state_next = LPW_S_OSCUP; // see RULE16
                    wcnt_next = 16'(`LPW_IRC_START_CYC); // see RULE14
                end
            end
            LPW_S_OSCUP: begin
                if (wcnt_reg <= 16'h0001) begin
                    state_next = LPW_S_WCNT;
                    wcnt_next = resume_cyc; // see RULE14
                end else begin
                    wcnt_next = wcnt_reg - 16'h0001;
                end
            end
            LPW_S_WCNT: begin
                if (wcnt_reg <= 16'h0001) begin
                    state_next = LPW_S_RUN;
                    wcnt_next = 16'h0000;
                end else begin
                    wcnt_next = wcnt_reg - 16'h0001;
                end
            end
            LPW_S_DPD: begin
                // Only the alarm wakes it; the reset pin is sys_rst
                if (alarm_s) begin
                    state_next = LPW_S_OSCUP; // see RULE19
                    wcnt_next = 16'(`LPW_IRC_START_CYC);
                end
            end
            default: state_next = LPW_S_RUN;
        endcase
    end

    // --------------------------------------------------------
    // Flash wake timer, started when power-down or DPD ends
    // --------------------------------------------------------
    wire flash_start = (state_reg == LPW_S_PDOWN ||
                        state_reg == LPW_S_DPD) &&
                       state_next == LPW_S_OSCUP;
    assign fcnt_next = flash_start ? 16'(`LPW_FLASH_CYC) :
                       (fcnt_reg != 16'h0000) ?
                       fcnt_reg - 16'h0001 : 16'h0000; // see RULE15

    // --------------------------------------------------------
    // Clock configuration: cleared by hardware on deep entry
    // --------------------------------------------------------
    // Hardware clear wins; software must rewrite after waking
    always_comb begin
        clkcfg_next = clkcfg_reg;
        if (wr && hit_cfg) begin
            clkcfg_next = wd[16:0]; // see RULE12
        end
        if (deep_entry || (state_reg == LPW_S_RUN && dpd_req_s)) begin
            clkcfg_next = `LPW_CLKCFG_RST; // see RULE7
        end
    end

    // --------------------------------------------------------
    // Power controls derived from the next state
    // --------------------------------------------------------
    wire nx_run = state_next == LPW_S_RUN;
    wire nx_sleep = state_next == LPW_S_SLEEP;
    wire nx_pd = state_next == LPW_S_PDOWN;
    wire nx_dpd = state_next == LPW_S_DPD;

    wire nx_pdlike = nx_pd || nx_dpd ||
                     ((state_next == LPW_S_OSCUP ||
                       state_next == LPW_S_WCNT) &&
                      (from_pd_reg || flash_start));

    wire flash_on = !nx_pdlike || state_next == LPW_S_WCNT ||
                    state_next == LPW_S_OSCUP;
    always_comb begin
        pwr_next.core_clk_en = nx_run; // see RULE1
        pwr_next.int_clk_en = nx_run || nx_sleep; // see RULE1, RULE4
        pwr_next.main_osc_en = (nx_run || nx_sleep) ||
                               (state_next == LPW_S_WCNT && src_main);
        pwr_next.irc_out_en = nx_run || nx_sleep ||
                              state_next == LPW_S_WCNT; // see RULE5
        // RC stays powered in deep-sleep, off only in power-down and DPD
        pwr_next.irc_pwr_en = !(nx_pd || nx_dpd); // see RULE5, RULE13
        // Flash kept up in deep-sleep for quick wake
        pwr_next.flash_pwr_en = flash_on && !nx_pd && !nx_dpd; // see RULE9
        pwr_next.flash_ready = pwr_next.flash_pwr_en &&
                               fcnt_next == 16'h0000; // see RULE15
        pwr_next.rtc_osc_en = 1'b1; // see RULE6
        pwr_next.chip_pwr_en = !nx_dpd; // see RULE18
        pwr_next.core_wake = nx_run && state_reg != LPW_S_RUN;
    end

    // --------------------------------------------------------
    // Sequencer and timer registers
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= LPW_S_RUN;
            wcnt_reg <= 16'h0000;
            fcnt_reg <= 16'h0000;
            from_pd_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            wcnt_reg <= wcnt_next;
            fcnt_reg <= fcnt_next;
            from_pd_reg <= nx_pdlike && !nx_run;
        end
    end

    // Wake mask is captured on entry and held while asleep
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_reg <= '0;
        end else if (clk_en && state_reg == LPW_S_RUN && core_wfi) begin
            mask_reg <= nic_wake_mask; // see RULE20
        end
    end

    // --------------------------------------------------------
    // Software registers
    // --------------------------------------------------------
    // Mode writes are blocked outside run so entry stays stable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_reg <= `LPW_MODE_RST;
            pgate_reg <= '1;
            clkcfg_reg <= `LPW_CLKCFG_RST;
        end else if (clk_en) begin
            if (wr && hit_mode && state_reg == LPW_S_RUN) begin
                mode_reg <= wd[2:0]; // see RULE23
            end
            if (wr && hit_pgate) begin
                pgate_reg <= wd[N_PERIPH-1:0]; // see RULE22
            end
            clkcfg_reg <= clkcfg_next;
        end
    end

    // --------------------------------------------------------
    // APB answer and registered outputs
    // --------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_reg <= '0;
        end else if (clk_en) begin
            rsp_reg.pready <= acc;
            rsp_reg.pslverr <= acc && !hit_any;
            rsp_reg.prdata <= (acc && !apb_req.pwrite) ? rd_data : 32'h0;
        end
    end

    // Peripheral clocks follow their gate bit and the internal clocks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_ctl <= '0;
            periph_clk_en <= '0;
            seq_state <= 3'h0;
            pll_en <= 1'b0;
            cpu_div <= 8'h00;
            usb_div <= 8'h00;
        end else if (clk_en) begin
            pwr_ctl <= pwr_next;
            periph_clk_en <= pgate_reg &
                {N_PERIPH{pwr_next.int_clk_en}}; // see RULE22, RULE4
            seq_state <= state_next;
            pll_en <= clkcfg_next[`LPW_PLLEN_BIT];
            cpu_div <= clkcfg_next[`LPW_CPUDIV_MSB:`LPW_CPUDIV_LSB];
            usb_div <= clkcfg_next[`LPW_USBDIV_MSB:`LPW_USBDIV_LSB];
        end
    end


    assign apb_rsp = rsp_reg;
endmodule : lpw_sequencer
`default_nettype wire

// [lpw_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef LPW_REGS_SVH
`define LPW_REGS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define LPW_OFS_MODE 12'h000
`define LPW_OFS_PGATE 12'h004
`define LPW_OFS_CLKCFG 12'h008
`define LPW_OFS_STATUS 12'h00c
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LPW_MODE_LSB 0
`define LPW_MODE_MSB 1
`define LPW_SRC_BIT 2
`define LPW_CPUDIV_LSB 0
`define LPW_CPUDIV_MSB 7
`define LPW_USBDIV_LSB 8
`define LPW_USBDIV_MSB 15
`define LPW_PLLEN_BIT 16
`define LPW_ST_LSB 0
`define LPW_ST_MSB 2
`define LPW_FRDY_BIT 3
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LPW_MODE_RST 3'h0
`define LPW_CLKCFG_RST 17'h00000
// ------------------------------------------------------------
// Timing: times as printed, counts derived for a 25 MHz clock
// ------------------------------------------------------------
`define LPW_CLK_MHZ 25
`define LPW_IRC_MHZ 4
`define LPW_IRC_START_US 60
`define LPW_IRC_WAKE_OSC 4
`define LPW_FLASH_US 100
`define LPW_OSC_WAKE_OSC 4096
`define LPW_IRC_START_CYC (`LPW_IRC_START_US * `LPW_CLK_MHZ)
`define LPW_IRC_WAKE_CYC \
    ((`LPW_IRC_WAKE_OSC * `LPW_CLK_MHZ + `LPW_IRC_MHZ - 1) / `LPW_IRC_MHZ)
`define LPW_FLASH_IRC_CNT (`LPW_FLASH_US * `LPW_IRC_MHZ)
`define LPW_FLASH_CYC (`LPW_FLASH_US * `LPW_CLK_MHZ)
`endif

// [lpw_pkg.sv]
// Types shared by the low-power mode and wake sequencer
`default_nettype none
package lpw_pkg;
    // --------------------------------------------------------
    // Low-power mode codes written by software
    // --------------------------------------------------------
    typedef enum logic [1:0] {
        LPW_M_SLEEP = 2'h0,
        LPW_M_DSLEEP = 2'h1,
        LPW_M_PDOWN = 2'h2,
        LPW_M_RSVD = 2'h3
    } lpw_mode_t;
    // --------------------------------------------------------
    // Sequencer states, Gray coded in the order listed
    // --------------------------------------------------------
    typedef enum logic [2:0] {
        LPW_S_RUN = 3'h0,
        LPW_S_SLEEP = 3'h1,
        LPW_S_DSLEEP = 3'h3,
        LPW_S_PDOWN = 3'h2,
        LPW_S_OSCUP = 3'h6,
        LPW_S_WCNT = 3'h7,
        LPW_S_DPD = 3'h5
    } lpw_state_t;
    // --------------------------------------------------------
    // APB request and answer
    // --------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lpw_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lpw_apb_rsp_t;
    // --------------------------------------------------------
    // Power and clock controls driven to the chip
    // --------------------------------------------------------
    typedef struct packed {
        logic core_clk_en;
        logic int_clk_en;
        logic main_osc_en;
        logic irc_out_en;
        logic irc_pwr_en;
        logic flash_pwr_en;
        logic flash_ready;
        logic rtc_osc_en;
        logic chip_pwr_en;
        logic core_wake;
    } lpw_pwr_t;
endpackage : lpw_pkg
`default_nettype wire

// [lpw_assertions.sv]
// Port-level concurrent checks for the low-power sequencer
`timescale 1ns/1ps
`default_nettype none
module lpw_assertions #(
    parameter logic [15:0] OSC_WAKE_CYC = 16'h1000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // RTC deep power-down request and alarm
    input wire logic rtc_dpd_req,
    input wire logic rtc_alarm,
    // Power and clock controls
    input wire lpw_pkg::lpw_pwr_t pwr_ctl,
    input wire logic pll_en,
    input wire logic [7:0] cpu_div,
    input wire logic [7:0] usb_div,
    input wire logic [2:0] seq_state
);
    import lpw_pkg::*;
    localparam logic [15:0] OSCUP_CYC = 16'h05dc;
    localparam logic [15:0] WCNT_RC = 16'h0019;
    logic [15:0] dwell_reg, dwell_next;
    logic [2:0] prev_reg;
    // Dwell counter saturates so a long run in RUN cannot wrap
    assign dwell_next = (seq_state != prev_reg) ? 16'h0001 :
        dwell_reg + 16'(dwell_reg != 16'hffff);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dwell_reg <= 16'h0000;
            prev_reg <= 3'h0;
        end else begin
            dwell_reg <= dwell_next;
            prev_reg <= seq_state;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sleep_clocks_a: assert property (
        seq_state == 3'h1 |-> !pwr_ctl.core_clk_en && pwr_ctl.int_clk_en)
        else $error("sleep clocks wrong");
    dsleep_clocks_a: assert property (
        seq_state == 3'h3 |-> !pwr_ctl.core_clk_en && !pwr_ctl.int_clk_en
        && !pwr_ctl.main_osc_en && !pwr_ctl.irc_out_en && pwr_ctl.irc_pwr_en
        && pwr_ctl.flash_pwr_en && pwr_ctl.rtc_osc_en)
        else $error("dsleep clocks wrong");
    deep_cfg_clear_a: assert property (
        seq_state inside {3'h3, 3'h2, 3'h5} |->
        !pll_en && cpu_div == 8'h00 && usb_div == 8'h00)
        else $error("clkcfg not cleared");
    pdown_power_a: assert property (
        seq_state == 3'h2 |-> !pwr_ctl.irc_pwr_en && !pwr_ctl.flash_pwr_en)
        else $error("pdown supplies wrong");
    dpd_power_a: assert property (
        seq_state == 3'h5 |-> !pwr_ctl.chip_pwr_en && pwr_ctl.rtc_osc_en)
        else $error("dpd supplies wrong");
    dpd_entry_a: assert property (
        prev_reg != 3'h5 && seq_state == 3'h5 |-> $past(rtc_dpd_req, 1)
        || $past(rtc_dpd_req, 2) || $past(rtc_dpd_req, 3))
        else $error("dpd entry without rtc");
    dpd_wake_a: assert property (
        prev_reg == 3'h5 && seq_state != 3'h5 |-> seq_state == 3'h6
        && ($past(rtc_alarm, 1) || $past(rtc_alarm, 2) || $past(rtc_alarm, 3)))
        else $error("dpd exit without alarm");
    pdown_timer_a: assert property (
        prev_reg == 3'h2 && seq_state != 3'h2 |-> seq_state == 3'h6)
        else $error("pdown wake skipped timer");
    oscup_len_a: assert property (
        prev_reg == 3'h6 && seq_state != 3'h6 |->
        dwell_reg == OSCUP_CYC && seq_state == 3'h7)
        else $error("oscup length wrong");
    wcnt_len_a: assert property (
        prev_reg == 3'h7 && seq_state != 3'h7 |-> seq_state == 3'h0
        && (dwell_reg == WCNT_RC || dwell_reg == OSC_WAKE_CYC))
        else $error("wake count length wrong");
    wake_pulse_a: assert property (
        prev_reg != 3'h0 && seq_state == 3'h0 |-> pwr_ctl.core_wake
        && pwr_ctl.core_clk_en ##1 !pwr_ctl.core_wake)
        else $error("core wake pulse wrong");
endmodule : lpw_assertions
`default_nettype wire

// [lpw_core_model.sv]
// Behavioural model of the processor core and its interrupt controller
`timescale 1ns/1ps
`default_nettype none
module lpw_core_model #(
    parameter int N_IRQ = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bench request and mask to hand over
    input wire logic wfi_go,
    input wire logic [N_IRQ-1:0] wfi_mask,
    // From the sequencer
    input wire logic core_clk_en,
    // To the sequencer
    output logic core_wfi,
    output logic [N_IRQ-1:0] nic_wake_mask
);
    // Stopped core cannot issue wfi; mask toggles so late capture shows
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            core_wfi <= 1'b0;
            nic_wake_mask <= '0;
        end else begin
            core_wfi <= wfi_go && core_clk_en;
            nic_wake_mask <= wfi_go ? wfi_mask : ~nic_wake_mask;
        end
    end
endmodule : lpw_core_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the low-power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "lpw_regs.svh"
module tb_top;
    import lpw_pkg::*;
    localparam logic [15:0] OSC_CYC = 16'h0008;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    lpw_apb_req_t apb_req = '0;
    lpw_apb_rsp_t apb_rsp;
    logic core_wfi, pll_en, err;
    logic [31:0] nic_wake_mask, periph_clk_en, rd;
    logic [31:0] irq_in = 32'h0;
    logic rtc_dpd_req = 1'b0;
    logic rtc_alarm = 1'b0;
    logic wfi_go = 1'b0;
    logic [31:0] wfi_mask = 32'h0;
    lpw_pwr_t pwr_ctl;
    logic [7:0] cpu_div, usb_div;
    logic [2:0] seq_state;
    int n_fail = 0, tests_run = 0, n;
    // 25 MHz clock
    always #20 clk = ~clk;
    lpw_sequencer #(.OSC_WAKE_CYC(OSC_CYC)) lpw_sequencer_inst (
        .clk, .sys_rst, .clk_en(1'b1), .apb_req, .apb_rsp, .core_wfi,
        .nic_wake_mask, .irq_in, .rtc_dpd_req, .rtc_alarm, .pwr_ctl,
        .pll_en, .cpu_div, .usb_div, .periph_clk_en, .seq_state);
    lpw_core_model lpw_core_model_inst (
        .clk, .sys_rst, .wfi_go, .wfi_mask,
        .core_clk_en(pwr_ctl.core_clk_en), .core_wfi, .nic_wake_mask);
    // ----------------
    // Shared tasks
    // ----------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // One APB transfer; the request holds until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 50);
        chk("pready", 32'h1, 32'(apb_rsp.pready));
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb
    task automatic rchk(input string what, input logic [11:0] a,
                        input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
        chk("pslverr", 32'(exp_err), 32'(err));
    endtask : rchk
    task automatic wait_st(input logic [2:0] s, input int lim);
        int k = 0;
        while (seq_state !== s && k < lim) begin
            @(posedge clk);
            k++;
        end
        chk("seq_state", 32'(s), 32'(seq_state));
    endtask : wait_st
    task automatic dwell(input logic [2:0] s, output int k);
        k = 0;
        while (seq_state === s && k < 5000) begin
            @(posedge clk);
            k++;
        end
    endtask : dwell
    task automatic enter(input logic [31:0] m);
        @(posedge clk);
        wfi_go <= 1'b1;
        wfi_mask <= m;
        @(posedge clk);
        wfi_go <= 1'b0;
    endtask : enter
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs();
        rchk("mode", `LPW_OFS_MODE, 32'h0, 1'b0);
        rchk("pgate", `LPW_OFS_PGATE, 32'hffffffff, 1'b0);
        rchk("clkcfg", `LPW_OFS_CLKCFG, 32'h0, 1'b0);
        rchk("status", `LPW_OFS_STATUS, 32'h8, 1'b0);
        rchk("unmapped", 12'h010, 32'h0, 1'b1);
        chk("run pwr_ctl", 32'h3fe, 32'(pwr_ctl));
        apb(1'b1, `LPW_OFS_PGATE, 32'h0000a5a5);
        @(posedge clk);
        chk("periph_clk_en", 32'h0000a5a5, periph_clk_en);
        apb(1'b1, `LPW_OFS_PGATE, 32'hffffffff);
    endtask : t_regs
    task automatic t_sleep();
        apb(1'b1, `LPW_OFS_MODE, 32'h0);
        enter(32'h0);
        wait_st(3'h1, 10);
        chk("sleep pwr_ctl", 32'h1fe, 32'(pwr_ctl));
        repeat (5) @(posedge clk);
        chk("seq_state", 32'h1, 32'(seq_state));
        irq_in <= 32'h20;
        wait_st(3'h0, 10);
        chk("core_wake", 32'h1, 32'(pwr_ctl.core_wake));
        irq_in <= 32'h0;
    endtask : t_sleep
    task automatic t_dsleep();
        apb(1'b1, `LPW_OFS_CLKCFG, 32'h00010302);
        apb(1'b1, `LPW_OFS_MODE, 32'h1);
        enter(32'h10);
        wait_st(3'h3, 10);
        chk("dsleep pwr_ctl", 32'h036, 32'(pwr_ctl & 10'h3f7));
        chk("clkcfg out", 32'h0, {15'h0, pll_en, usb_div, cpu_div});
        irq_in <= 32'h08;
        repeat (10) @(posedge clk);
        chk("seq_state", 32'h3, 32'(seq_state));
        chk("periph_clk_en", 32'h0, periph_clk_en);
        irq_in <= 32'h18;
        wait_st(3'h7, 10);
        dwell(3'h7, n);
        chk("rc wake cycles", 32'h19, 32'(n));
        apb(1'b1, `LPW_OFS_CLKCFG, 32'h00010302);
        @(posedge clk);
        chk("pll_en", 32'h1, 32'(pll_en));
        irq_in <= 32'h0;
    endtask : t_dsleep
    task automatic t_pdown();
        apb(1'b1, `LPW_OFS_MODE, 32'h6);
        enter(32'h10);
        wait_st(3'h2, 10);
        chk("pdown pwr_ctl", 32'h006, 32'(pwr_ctl));
        irq_in <= 32'h10;
        wait_st(3'h6, 10);
        dwell(3'h6, n);
        chk("osc start cycles", 32'h5dc, 32'(n));
        dwell(3'h7, n);
        chk("main osc cycles", 32'(OSC_CYC), 32'(n));
        chk("flash_ready", 32'h0, 32'(pwr_ctl.flash_ready));
        repeat (1100) @(posedge clk);
        chk("flash_ready", 32'h1, 32'(pwr_ctl.flash_ready));
        irq_in <= 32'h0;
    endtask : t_pdown
    task automatic t_dpd();
        apb(1'b1, `LPW_OFS_MODE, 32'h3);
        enter(32'hffffffff);
        repeat (5) @(posedge clk);
        chk("seq_state", 32'h0, 32'(seq_state));
        rtc_dpd_req <= 1'b1;
        wait_st(3'h5, 10);
        rtc_dpd_req <= 1'b0;
        chk("dpd pwr_ctl", 32'h004, 32'(pwr_ctl));
        irq_in <= 32'hffffffff;
        repeat (10) @(posedge clk);
        chk("seq_state", 32'h5, 32'(seq_state));
        irq_in <= 32'h0;
        rtc_alarm <= 1'b1;
        wait_st(3'h6, 10);
        rtc_alarm <= 1'b0;
        wait_st(3'h0, 2000);
    endtask : t_dpd
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // Main sequence, reset held three cycles
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_sleep();
        t_dsleep();
        t_pdown();
        t_dpd();
        end_sim();
    end
    // Watchdog, nearly five times the expected run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end
endmodule : tb_top
bind lpw_sequencer lpw_assertions #(.OSC_WAKE_CYC(OSC_WAKE_CYC))
    lpw_assertions_inst (.clk, .sys_rst, .rtc_dpd_req, .rtc_alarm, .pwr_ctl,
    .pll_en, .cpu_div, .usb_div, .seq_state);
`default_nettype wire
